// ===== sample_flags_map.svh
// Register offsets, field positions, reset values for the sample buffer flags
`ifndef SAMPLE_FLAGS_MAP_SVH
`define SAMPLE_FLAGS_MAP_SVH

`define FLAG_REG_OFS 8'h3b
`define CTRL_REG_OFS 8'h40
`define SETUP_REG_OFS 8'h41
`define GEN_STATUS_OFS 8'h42
`define IRQ_STATUS_OFS 8'h43
`define IRQ_MASK_OFS 8'h44

`define FLAG_AGG_BIT 7
`define FLAG_STORE_BIT 6
`define FLAG_FETCH_BIT 5
`define FLAG_EMPTY_BIT 0
`define GEN_AGG_BIT 6
`define SETUP_STORE_IE_BIT 14
`define SETUP_FETCH_IE_BIT 13

`define FLAG_REG_RESET 8'h01
`define CTRL_REG_RESET 16'h0000
`define SETUP_REG_RESET 16'h0200
`define IRQ_MASK_RESET 2'h0

`define BUF_DEPTH 256
`define TARGET_FULL 9'h100

`endif

// ===== sample_flags_pkg.sv
// Types shared by the sample buffer flag logic
`default_nettype none
package sample_flags_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_OLDEST = 2'h1,
    MODE_WATERMARK = 2'h2,
    MODE_STREAM = 2'h3
  } buffer_mode_t;

  typedef enum logic [1:0] {
    FILL_OPEN = 2'b01,
    FILL_HELD = 2'b10
  } fill_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic agg;
    logic store_fail;
    logic fetch_fail;
  } err_flags_t;

endpackage : sample_flags_pkg
`default_nettype wire

// ===== fill_level_counter.sv
// Occupancy counter of the conversion-result buffer
`timescale 1ns/1ps
`default_nettype none
module fill_level_counter #(
  parameter int DEPTH = 256
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("fill_level_counter: DEPTH must be at least 2");
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (push_i && !pop_i && count_o != CW'(DEPTH)) begin
      count_o <= count_o + CW'(1);
    end else if (pop_i && !push_i && count_o != '0) begin
      count_o <= count_o - CW'(1);
    end
  end

  count_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    count_o <= CW'(DEPTH)) else $error("buffer count above depth");

endmodule : fill_level_counter
`default_nettype wire

// ===== sticky_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module sticky_irq #(
  parameter int N = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] event_i,
  input wire logic [N-1:0] clear_i,
  input wire logic [N-1:0] mask_i,
  output logic [N-1:0] status_o,
  output logic irq_o
);
  logic [N-1:0] status_next;

  if (N < 1) begin : g_bad_n
    $error("sticky_irq: N must be at least 1");
  end

  // A new event beats a clear in the same cycle
  always_comb begin
    status_next = (status_o & ~clear_i) | event_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= status_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_next & mask_i);
    end
  end

  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    irq_o == |(status_o & $past(mask_i))) else $error("irq level mismatch");

endmodule : sticky_irq
`default_nettype wire

// ===== sample_flags_top.sv
// Error flag logic of the conversion-result buffer
//
// Functional notes
// - Error flags may set only in watermark or streaming mode.
// - Aggregate flag bit 7 is the OR of all buffer error bits.
// - General status aggregate error bit follows the buffer aggregate flag.
// - Watermark: result dropped by host read or held target sets store-fail.
// - Watermark: buffer held full at target until completely emptied.
// - Watermark: store-fail behaves exactly like the overflow indicator.
// - Streaming: store-fail sets only when a host read blocks storing.
// - Store-fail clears when the buffer becomes empty.
// - Flag interrupt rises and falls in the same cycle as its flag.
// - Flag register read-only, resets to 0x01, error flags zero.
// - Store-fail interrupt only when setup bit 14 is one.
// - Eight-bit target; zero means 256, else N conversions.
// - Fetch-fail bit 5 sets on refused read, clears on grant or empty.
`timescale 1ns/1ps
`default_nettype none
`include "sample_flags_map.svh"
module sample_flags_top #(
  parameter int DEPTH = `BUF_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire sample_flags_pkg::reg_req_t bus_req_i,
  input wire logic conv_i,
  input wire logic fetch_req_i,
  input wire logic host_read_busy_i,
  output logic [15:0] rdata_o,
  output logic stored_o,
  output logic fetch_grant_o,
  output logic main_err_o,
  output logic flag_irq_o,
  output logic irq_o
);
  import sample_flags_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH != `BUF_DEPTH) begin : g_bad_depth
    $error("sample_flags_top: target coding needs a depth of 256");
  end

  // Zero selects the whole buffer
  function automatic logic [8:0] fill_target(input logic [7:0] wm);
    fill_target = (wm == 8'h00) ? `TARGET_FULL : {1'b0, wm};
  endfunction : fill_target

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [15:0] ctrl_reg;
  logic [15:0] setup_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_status;
  err_flags_t flags_reg;
  err_flags_t flags_next;
  fill_state_t state_reg;
  fill_state_t state_next;
  logic [CW-1:0] count;
  logic [8:0] target;
  buffer_mode_t mode;
  logic wm_mode;
  logic st_mode;
  logic flags_on;
  logic empty;
  logic full_now;
  logic held;
  logic store_refused;
  logic store_ok;
  logic fetch_ok;
  logic fetch_refused;
  logic pop;
  logic [1:0] irq_events;
  logic [1:0] irq_clear;
  logic irq_line;

  always_comb begin
    mode = buffer_mode_t'(ctrl_reg[1:0]);
    wm_mode = (mode == MODE_WATERMARK);
    st_mode = (mode == MODE_STREAM);
    flags_on = wm_mode || st_mode;
    target = fill_target(setup_reg[7:0]);
    empty = (count == '0);
    full_now = (count == CW'(DEPTH));
    held = (state_reg == FILL_HELD);
  end

  // A result is dropped while the host reads, or while the target holds
  always_comb begin
    store_refused = conv_i
                    && (host_read_busy_i || (wm_mode && held));
    store_ok = conv_i && !store_refused;
    fetch_refused = fetch_req_i && conv_i;
    fetch_ok = fetch_req_i && !conv_i && !empty;
    // Outside watermark mode a full buffer gives up its oldest result
    pop = fetch_ok || (store_ok && full_now);
  end

  fill_level_counter #(
    .DEPTH(DEPTH)
  ) u_level (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .push_i(store_ok),
    .pop_i(pop),
    .count_o(count)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FILL_OPEN: begin
        if (wm_mode && store_ok && (9'(count) + 9'h001 >= target)) begin
          state_next = FILL_HELD;
        end
      end
      FILL_HELD: begin
        // Only a fully drained buffer or leaving watermark mode reopens; partial reads do not
        if (!wm_mode || empty) begin
          state_next = FILL_OPEN;
        end
      end
      default: begin
        state_next = FILL_OPEN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= FILL_OPEN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Set wins over the empty clear so a drop in the same cycle is kept
  always_comb begin
    flags_next = flags_reg;
    if (!flags_on) begin
      flags_next.store_fail = 1'b0;
    end else if (store_refused) begin
      flags_next.store_fail = 1'b1;
    end else if (empty) begin
      flags_next.store_fail = 1'b0;
    end
    if (!flags_on) begin
      flags_next.fetch_fail = 1'b0;
    end else if (fetch_refused) begin
      flags_next.fetch_fail = 1'b1;
    end else if (fetch_ok || empty) begin
      flags_next.fetch_fail = 1'b0;
    end
    flags_next.agg = flags_next.store_fail || flags_next.fetch_fail;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      main_err_o <= 1'b0;
    end else begin
      main_err_o <= flags_next.agg;
    end
  end

  // Built from next values so the pin moves with the flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_irq_o <= 1'b0;
    end else begin
      flag_irq_o <= (flags_next.store_fail
                     && setup_reg[`SETUP_STORE_IE_BIT])
                    || (flags_next.fetch_fail
                     && setup_reg[`SETUP_FETCH_IE_BIT]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stored_o <= 1'b0;
      fetch_grant_o <= 1'b0;
    end else begin
      stored_o <= store_ok;
      fetch_grant_o <= fetch_ok;
    end
  end

  always_comb begin
    // Without its enable a flag raises no interrupt event at all
    irq_events[0] = flags_next.store_fail && !flags_reg.store_fail
                    && setup_reg[`SETUP_STORE_IE_BIT];
    irq_events[1] = flags_next.fetch_fail && !flags_reg.fetch_fail
                    && setup_reg[`SETUP_FETCH_IE_BIT];
    irq_clear = (bus_req_i.wr && hit(bus_req_i.addr, `IRQ_STATUS_OFS))
                ? bus_req_i.wdata[1:0] : 2'h0;
  end

  sticky_irq #(
    .N(2)
  ) u_irq (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .event_i(irq_events),
    .clear_i(irq_clear),
    .mask_i(irq_mask_reg),
    .status_o(irq_status),
    .irq_o(irq_line)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_line;
    end
  end

  // Writes to the flag register fall through: it has no storage to write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_REG_RESET;
      setup_reg <= `SETUP_REG_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
    end else if (bus_req_i.wr) begin
      if (hit(bus_req_i.addr, `CTRL_REG_OFS)) begin
        ctrl_reg <= {14'h0000, bus_req_i.wdata[1:0]};
      end
      if (hit(bus_req_i.addr, `SETUP_REG_OFS)) begin
        setup_reg <= {1'b0, bus_req_i.wdata[14:8], bus_req_i.wdata[7:0]};
      end
      if (hit(bus_req_i.addr, `IRQ_MASK_OFS)) begin
        irq_mask_reg <= bus_req_i.wdata[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        `FLAG_REG_OFS: begin
          rdata_o <= {8'h00, flags_reg.agg, flags_reg.store_fail,
                      flags_reg.fetch_fail, 4'h0, empty};
        end
        `CTRL_REG_OFS: begin
          rdata_o <= ctrl_reg;
        end
        `SETUP_REG_OFS: begin
          rdata_o <= setup_reg;
        end
        `GEN_STATUS_OFS: begin
          rdata_o <= {9'h000, flags_reg.agg, 6'h00};
        end
        `IRQ_STATUS_OFS: begin
          rdata_o <= {14'h0000, irq_status};
        end
        `IRQ_MASK_OFS: begin
          rdata_o <= {14'h0000, irq_mask_reg};
        end
        default: begin
          rdata_o <= 16'h0000;
        end
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence drop_while_held;
    wm_mode && held && conv_i;
  endsequence

  sequence flag_set_next;
    ##1 flags_reg.store_fail;
  endsequence

  flags_off_a: assert property (
    !flags_on |=> !flags_reg.store_fail && !flags_reg.fetch_fail)
    else $error("error flag set outside watermark or streaming mode");

  agg_or_a: assert property (
    flags_reg.agg == (flags_reg.store_fail || flags_reg.fetch_fail))
    else $error("aggregate flag not the OR of the error flags");

  main_mirror_a: assert property (
    main_err_o == flags_reg.agg)
    else $error("general aggregate error differs from buffer flag");

  wm_busy_drop_a: assert property (
    wm_mode && conv_i && host_read_busy_i |-> flag_set_next)
    else $error("dropped result during host read not flagged");

  wm_hold_a: assert property (
    drop_while_held ##0 !fetch_req_i |=> count == $past(count))
    else $error("result stored while held at target");

  overflow_like_a: assert property (
    drop_while_held |-> flag_set_next)
    else $error("drop at target not flagged like overflow");

  stream_ok_a: assert property (
    st_mode && conv_i && !host_read_busy_i && !flags_reg.store_fail
    |=> !flags_reg.store_fail)
    else $error("store-fail set in streaming without host read");

  empty_clear_a: assert property (
    flags_on && empty && !conv_i |=> !flags_reg.store_fail)
    else $error("store-fail not cleared on empty buffer");

  irq_follow_a: assert property (
    flag_irq_o == ((flags_reg.store_fail
                    && $past(setup_reg[`SETUP_STORE_IE_BIT]))
                   || (flags_reg.fetch_fail
                    && $past(setup_reg[`SETUP_FETCH_IE_BIT]))))
    else $error("flag interrupt out of step with flags");

  fetch_fail_a: assert property (
    flags_on && conv_i && fetch_req_i |=> flags_reg.fetch_fail [*1])
    else $error("refused read not flagged");

  irq_gate_a: assert property (
    irq_status[0] && !$past(irq_status[0])
    |-> $past(setup_reg[`SETUP_STORE_IE_BIT]))
    else $error("store-fail interrupt event without its enable");

  hold_until_empty_a: assert property (
    wm_mode && held && !empty |=> held)
    else $error("hold released before buffer emptied");

  grant_clear_a: assert property (
    flags_on && fetch_ok |=> !flags_reg.fetch_fail)
    else $error("granted read left fetch-fail set");

  stream_store_a: assert property (
    st_mode && conv_i && !host_read_busy_i |=> stored_o)
    else $error("streaming result refused without host read");

endmodule : sample_flags_top
`default_nettype wire

// ===== host_reader.sv
// Host-side model that pops conversion results and holds buffer reads
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input wire logic ref_clk_i,
  output logic fetch_req_o,
  output logic read_busy_o
);
  initial begin
    fetch_req_o = 1'b0;
    read_busy_o = 1'b0;
  end

  // One pop request, launched and dropped on rising edges only
  task automatic pop();
    @(posedge ref_clk_i);
    fetch_req_o <= 1'b1;
    @(posedge ref_clk_i);
    fetch_req_o <= 1'b0;
  endtask : pop

  // A long host read keeps the buffer locked against stores
  task automatic set_busy(input logic b);
    @(posedge ref_clk_i);
    read_busy_o <= b;
  endtask : set_busy
endmodule : host_reader
`default_nettype wire

// ===== adc_sample_buffer_status_flags_test.sv
// Self-checking bench for the sample buffer error flags
`timescale 1ns/1ps
`default_nettype none
`include "sample_flags_map.svh"
module adc_sample_buffer_status_flags_test;
  import sample_flags_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  reg_req_t bus_req;
  logic conv;
  logic fetch_req;
  logic host_busy;
  logic [15:0] rdata;
  logic stored, grant, main_err, flag_irq, irq;
  int n_errors = 0;
  int n_tests = 0;

  sample_flags_top dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req),
    .conv_i(conv), .fetch_req_i(fetch_req), .host_read_busy_i(host_busy),
    .rdata_o(rdata), .stored_o(stored), .fetch_grant_o(grant),
    .main_err_o(main_err), .flag_irq_o(flag_irq), .irq_o(irq)
  );

  host_reader host_u (
    .ref_clk_i(ref_clk_i),
    .fetch_req_o(fetch_req),
    .read_busy_o(host_busy)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk_i);
    bus_req <= '0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp,
                        input string what);
    @(posedge ref_clk_i);
    bus_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_i);
    bus_req <= '0;
    #1;
    check(rdata, exp, what);
  endtask : reg_rd

  task automatic store(input logic exp);
    @(posedge ref_clk_i);
    conv <= 1'b1;
    @(posedge ref_clk_i);
    conv <= 1'b0;
    #1;
    check({15'h0000, stored}, {15'h0000, exp}, "stored pulse");
  endtask : store

  task automatic pop_ok();
    host_u.pop();
    #1;
    check({15'h0000, grant}, 16'h0001, "fetch grant");
  endtask : pop_ok

  task automatic test_reset();
    reg_rd(`FLAG_REG_OFS, 16'h0001, "flag reset");
    reg_wr(`FLAG_REG_OFS, 16'h00ff);
    reg_rd(`FLAG_REG_OFS, 16'h0001, "flag read-only");
    reg_rd(8'h7f, 16'h0000, "unmapped read");
    check({15'h0000, main_err}, 16'h0000, "main error at reset");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_mode_off();
    // Off and oldest-first modes must never raise an error flag
    for (int m = 0; m < 2; m++) begin
      reg_wr(`CTRL_REG_OFS, 16'(m));
      host_u.set_busy(1'b1);
      store(1'b0);
      host_u.set_busy(1'b0);
      fork
        host_u.pop();
        store(1'b1);
      join
      reg_rd(`FLAG_REG_OFS, 16'h0000, "no flag when off");
      pop_ok();
      reg_rd(`FLAG_REG_OFS, 16'h0001, "empty again");
    end
    $display("test_mode_off done");
  endtask : test_mode_off

  task automatic test_mid_reset();
    reg_wr(`CTRL_REG_OFS, 16'h0002);
    reg_wr(`SETUP_REG_OFS, 16'h4000);
    store(1'b1);
    store(1'b1);
    host_u.set_busy(1'b1);
    store(1'b0);
    host_u.set_busy(1'b0);
    reg_rd(`FLAG_REG_OFS, 16'h00c0, "busy drop in watermark");
    check({15'h0000, flag_irq}, 16'h0001, "flag irq before reset");
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reg_rd(`FLAG_REG_OFS, 16'h0001, "flags after reset");
    check({15'h0000, main_err}, 16'h0000, "main error after reset");
    check({15'h0000, flag_irq}, 16'h0000, "flag irq after reset");
    check({15'h0000, irq}, 16'h0000, "irq after reset");
    $display("test_mid_reset done");
  endtask : test_mid_reset

  task automatic test_watermark();
    reg_wr(`CTRL_REG_OFS, 16'h0002);
    reg_wr(`SETUP_REG_OFS, 16'h4001);
    store(1'b1);
    store(1'b0);
    reg_rd(`FLAG_REG_OFS, 16'h00c0, "store fail at target");
    reg_rd(`GEN_STATUS_OFS, 16'h0040, "general aggregate");
    check({15'h0000, main_err}, 16'h0001, "main error");
    check({15'h0000, flag_irq}, 16'h0001, "flag irq up");
    reg_wr(`IRQ_MASK_OFS, 16'h0001);
    reg_rd(`IRQ_STATUS_OFS, 16'h0001, "sticky status");
    check({15'h0000, irq}, 16'h0001, "irq line up");
    pop_ok();
    reg_rd(`FLAG_REG_OFS, 16'h0001, "cleared on empty");
    check({15'h0000, flag_irq}, 16'h0000, "flag irq down");
    check({15'h0000, main_err}, 16'h0000, "main error down");
    reg_wr(`IRQ_STATUS_OFS, 16'h0001);
    reg_rd(`IRQ_STATUS_OFS, 16'h0000, "status cleared");
    check({15'h0000, irq}, 16'h0000, "irq line down");
    store(1'b1);
    $display("test_watermark done");
  endtask : test_watermark

  task automatic test_stream();
    pop_ok();
    reg_wr(`CTRL_REG_OFS, 16'h0003);
    reg_wr(`SETUP_REG_OFS, 16'h0000);
    store(1'b1);
    store(1'b1);
    host_u.set_busy(1'b1);
    store(1'b0);
    host_u.set_busy(1'b0);
    reg_rd(`FLAG_REG_OFS, 16'h00c0, "stream store fail");
    check({15'h0000, flag_irq}, 16'h0000, "irq disabled");
    check({15'h0000, irq}, 16'h0000, "irq gated by enable");
    fork
      host_u.pop();
      store(1'b1);
    join
    check({15'h0000, grant}, 16'h0000, "fetch refused");
    reg_rd(`FLAG_REG_OFS, 16'h00e0, "fetch fail set");
    pop_ok();
    reg_rd(`FLAG_REG_OFS, 16'h00c0, "fetch fail cleared");
    pop_ok();
    pop_ok();
    reg_rd(`FLAG_REG_OFS, 16'h0001, "stream cleared on empty");
    $display("test_stream done");
  endtask : test_stream

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // The whole sequence needs about 120 cycles; this is ample margin
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst_i = 1'b1;
    bus_req = '0;
    conv = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_mode_off();
    test_watermark();
    test_stream();
    test_mid_reset();
    end_of_test();
  end
endmodule : adc_sample_buffer_status_flags_test
`default_nettype wire
